// >>> verilog/ccu_pkg.sv
// package of constants for the combined custom instruction unit
package ccu_pkg;
  localparam int CCU_DATA_W = 32;
  localparam int CCU_SEL_W = 2;
  localparam int CCU_NUM_FN = 4;
  // function selector codes
  localparam logic [1:0] CCU_FN_ADD = 2'h0;
  localparam logic [1:0] CCU_FN_XOR = 2'h1;
  localparam logic [1:0] CCU_FN_MUL = 2'h2;
  localparam logic [1:0] CCU_FN_ROT = 2'h3;
  // fixed latency of the merged functions, in clock cycles
  localparam int CCU_ADD_LAT = 1;
  localparam int CCU_XOR_LAT = 1;
  localparam int CCU_MUL_LAT = 3;
  localparam int CCU_ROT_LAT = 2;
  localparam int CCU_MAX_LAT = 3;
  localparam logic [31:0] CCU_RESULT_RST = 32'h0000_0000;
endpackage

// >>> verilog/ccu_delay_line.sv
// start-bit shift chain that turns a fixed latency into a done pulse
`timescale 1ns/1ps
`default_nettype none
module ccu_delay_line
  import ccu_pkg::*;
#(
  parameter int DEPTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // start in, delayed done out
  input wire logic start,
  output logic done
);
  logic [DEPTH-1:0] chain;
  logic [DEPTH-1:0] next_chain;

  // split at elaboration so a one-stage chain never forms a negative slice
  generate
    if (DEPTH == 1) begin : g_one
      always_comb begin
        next_chain = start;
      end
    end else begin : g_many
      always_comb begin
        next_chain = {chain[DEPTH-2:0], start};
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chain <= '0;
    end else begin
      chain <= next_chain;
    end
  end

  assign done = chain[DEPTH-1];
endmodule // ccu_delay_line
`default_nettype wire

// >>> verilog/ccu_unit.sv
// combined custom instruction unit with four merged functions
`timescale 1ns/1ps
`default_nettype none
module ccu_unit
  import ccu_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // custom instruction slave port, request side
  input wire logic start,
  input wire logic [CCU_SEL_W-1:0] n,
  input wire logic [CCU_DATA_W-1:0] dataa,
  input wire logic [CCU_DATA_W-1:0] datab,
  // custom instruction slave port, answer side
  output logic done,
  output logic [CCU_DATA_W-1:0] result
);
  typedef enum logic {CCU_IDLE, CCU_BUSY} ccu_state_t;

  ccu_state_t state;
  ccu_state_t next_state;
  logic [CCU_SEL_W-1:0] sel;
  logic [CCU_SEL_W-1:0] next_sel;
  logic [CCU_DATA_W-1:0] opa;
  logic [CCU_DATA_W-1:0] opb;
  logic [CCU_DATA_W-1:0] next_opa;
  logic [CCU_DATA_W-1:0] next_opb;
  // per-function pipelines
  logic [CCU_DATA_W-1:0] add_q;
  logic [CCU_DATA_W-1:0] xor_q;
  logic [CCU_DATA_W-1:0] mul_q0;
  logic [CCU_DATA_W-1:0] mul_q1;
  logic [CCU_DATA_W-1:0] mul_q2;
  logic [CCU_DATA_W-1:0] rot_q0;
  logic [CCU_DATA_W-1:0] rot_q1;
  logic [CCU_DATA_W-1:0] next_add;
  logic [CCU_DATA_W-1:0] next_xor;
  logic [CCU_DATA_W-1:0] next_mul0;
  logic [CCU_DATA_W-1:0] next_rot0;
  logic [63:0] mul_full;
  logic [CCU_NUM_FN-1:0] fn_start;
  logic [CCU_NUM_FN-1:0] fn_done;
  logic any_done;
  logic [CCU_DATA_W-1:0] next_result;
  logic next_done;
  logic launch;

  // a start while busy is ignored; the processor never issues one
  assign launch = start && (state == CCU_IDLE);

  always_comb begin
    next_state = state;
    next_sel = sel;
    next_opa = opa;
    next_opb = opb;
    case (state)
      CCU_IDLE: begin
        if (launch) begin
          next_state = CCU_BUSY;
          next_sel = n;
          next_opa = dataa;
          next_opb = datab;
        end
      end
      CCU_BUSY: begin
        if (any_done) begin
          next_state = CCU_IDLE;
        end
      end
      default: next_state = CCU_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= CCU_IDLE;
      sel <= '0;
      opa <= '0;
      opb <= '0;
    end else begin
      state <= next_state;
      sel <= next_sel;
      opa <= next_opa;
      opb <= next_opb;
    end
  end

  // start reaches only the selected function's chain
  genvar gi;
  generate
    for (gi = 0; gi < CCU_NUM_FN; gi++) begin : g_fn
      localparam int LAT = (gi == 0) ? CCU_ADD_LAT : (gi == 1) ? CCU_XOR_LAT :
                           (gi == 2) ? CCU_MUL_LAT : CCU_ROT_LAT;
      assign fn_start[gi] = launch && (n == CCU_SEL_W'(gi));
      ccu_delay_line #(.DEPTH(LAT)) u_dl (
        .clk(clk),
        .rst_n(rst_n),
        .start(fn_start[gi]),
        .done(fn_done[gi])
      );
    end
  endgenerate

  assign any_done = |fn_done;

  // operand datapaths, timed to their chains
  always_comb begin
    mul_full = dataa * datab;
    next_add = dataa + datab;
    next_xor = dataa ^ datab;
    next_mul0 = mul_full[CCU_DATA_W-1:0];
    next_rot0 = (dataa << datab[4:0]) | (dataa >> (6'h20 - {1'b0, datab[4:0]}));
    if (datab[4:0] == 5'h00) begin
      next_rot0 = dataa;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      add_q <= '0;
      xor_q <= '0;
      mul_q0 <= '0;
      mul_q1 <= '0;
      mul_q2 <= '0;
      rot_q0 <= '0;
      rot_q1 <= '0;
    end else begin
      add_q <= next_add;
      xor_q <= next_xor;
      mul_q0 <= next_mul0;
      mul_q1 <= mul_q0;
      mul_q2 <= mul_q1;
      rot_q0 <= next_rot0;
      rot_q1 <= rot_q0;
    end
  end

  // registered output mux keeps the select off the processor's critical path
  always_comb begin
    next_done = any_done && (state == CCU_BUSY);
    next_result = CCU_RESULT_RST;
    // captured selector steers the mux; it stands until the next launch
    if (any_done) begin
      case (sel)
        CCU_FN_ADD: next_result = add_q;
        CCU_FN_XOR: next_result = xor_q;
        CCU_FN_MUL: next_result = mul_q2;
        default: next_result = rot_q1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done <= 1'b0;
      result <= CCU_RESULT_RST;
    end else begin
      done <= next_done;
      result <= next_result;
    end
  end

  // helper: expected result captured at launch
  // worked out apart from the datapath so a datapath slip shows
  logic [CCU_DATA_W-1:0] exp_res;
  logic [63:0] exp_rot;
  assign exp_rot = {dataa, dataa} << datab[4:0];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      exp_res <= '0;
    end else if (launch) begin
      case (n)
        CCU_FN_ADD: exp_res <= dataa + datab;
        CCU_FN_XOR: exp_res <= dataa ^ datab;
        CCU_FN_MUL: exp_res <= dataa * datab;
        default: exp_res <= exp_rot[63:32];
      endcase
    end
  end

  property p_done_pulse;
    @(posedge clk) disable iff (!rst_n) done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");

  property p_add_lat;
    @(posedge clk) disable iff (!rst_n) (launch && n == CCU_FN_ADD) |-> ##2 done;
  endproperty
  a_add_lat: assert property (p_add_lat) else $error("add latency wrong");

  property p_mul_lat;
    @(posedge clk) disable iff (!rst_n)
      (launch && n == CCU_FN_MUL) |=> !done [*3] ##1 done;
  endproperty
  a_mul_lat: assert property (p_mul_lat) else $error("multiply latency wrong");

  property p_rot_lat;
    @(posedge clk) disable iff (!rst_n)
      (launch && n == CCU_FN_ROT) |=> !done [*2] ##1 done;
  endproperty
  a_rot_lat: assert property (p_rot_lat) else $error("rotate latency wrong");

  property p_result_ok;
    @(posedge clk) disable iff (!rst_n) done |-> result == exp_res;
  endproperty
  a_result_ok: assert property (p_result_ok) else $error("result mismatch");

  property p_xor_val;
    @(posedge clk) disable iff (!rst_n)
      (launch && n == CCU_FN_XOR) |-> ##2 (result == ($past(dataa, 2) ^ $past(datab, 2)));
  endproperty
  a_xor_val: assert property (p_xor_val) else $error("xor result wrong");

  property p_busy_until_done;
    @(posedge clk) disable iff (!rst_n) (state == CCU_BUSY && !any_done) |=> state == CCU_BUSY;
  endproperty
  a_busy_until_done: assert property (p_busy_until_done) else $error("left busy early");

  property p_done_has_cause;
    @(posedge clk) disable iff (!rst_n) done |-> $past(state == CCU_BUSY);
  endproperty
  a_done_has_cause: assert property (p_done_has_cause) else $error("done with no op");

  property p_one_fn;
    @(posedge clk) disable iff (!rst_n) $onehot0(fn_done);
  endproperty
  a_one_fn: assert property (p_one_fn) else $error("two functions done at once");

  property p_two_ops;
    @(posedge clk) disable iff (!rst_n) launch |=> (opa == $past(dataa) && opb == $past(datab));
  endproperty
  a_two_ops: assert property (p_two_ops) else $error("operands not captured");

  c_add: cover property (@(posedge clk) disable iff (!rst_n) launch && n == CCU_FN_ADD ##2 done);
  c_mul: cover property (@(posedge clk) disable iff (!rst_n) launch && n == CCU_FN_MUL ##4 done);
  c_rot: cover property (@(posedge clk) disable iff (!rst_n) launch && n == CCU_FN_ROT ##3 done);
  // closest spacing the blocking master gives: done seen, request, then start
  c_b2b: cover property (@(posedge clk) disable iff (!rst_n) done ##3 launch);
endmodule // ccu_unit
`default_nettype wire

// >>> sim/ccu_cpu_model.sv
// processor-side custom instruction master model, one blocking op at a time
`timescale 1ns/1ps
`default_nettype none
module ccu_cpu_model
  import ccu_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request from the bench
  input wire logic req,
  input wire logic [CCU_SEL_W-1:0] req_n,
  input wire logic [CCU_DATA_W-1:0] req_a,
  input wire logic [CCU_DATA_W-1:0] req_b,
  // master side of the slave port
  output logic start,
  output logic [CCU_SEL_W-1:0] n,
  output logic [CCU_DATA_W-1:0] dataa,
  output logic [CCU_DATA_W-1:0] datab,
  input wire logic done,
  input wire logic [CCU_DATA_W-1:0] result,
  // captured answer
  output logic busy,
  output logic stray,
  output logic [7:0] lat,
  output logic [CCU_DATA_W-1:0] res
);
  logic [7:0] cnt;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start <= 1'b0;
      busy <= 1'b0;
      stray <= 1'b0;
      cnt <= 8'h00;
      n <= '0;
      dataa <= '0;
      datab <= '0;
      lat <= 8'h00;
      res <= '0;
    end else begin
      start <= 1'b0;
      // operands only valid with start; scramble after so late sampling shows
      if (start) begin
        n <= ~n;
        dataa <= ~dataa;
        datab <= ~datab;
      end
      if (done && !busy) begin
        stray <= 1'b1;
      end
      if (req && !busy) begin
        start <= 1'b1;
        n <= req_n;
        dataa <= req_a;
        datab <= req_b;
        busy <= 1'b1;
        cnt <= 8'h00;
      end else if (busy) begin
        cnt <= cnt + 8'h01;
        if (done) begin
          busy <= 1'b0;
          res <= result;
          lat <= cnt;
        end
      end
    end
  end
endmodule // ccu_cpu_model
`default_nettype wire

// >>> sim/combined_custom_instruction_unit_tb.sv
// self-checking bench for the combined custom instruction unit
`timescale 1ns/1ps
`default_nettype none
module combined_custom_instruction_unit_tb;
  import ccu_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic [1:0] req_n = 2'h0;
  logic [31:0] req_a = 32'h0;
  logic [31:0] req_b = 32'h0;
  logic start, done, busy, stray;
  logic [1:0] n;
  logic [31:0] dataa, datab, result, res;
  logic [7:0] lat;
  int miscompares = 0;
  int checks = 0;

  always #2.5 clk = ~clk;

  ccu_unit u_dut (.clk(clk), .rst_n(rst_n), .start(start), .n(n), .dataa(dataa),
    .datab(datab), .done(done), .result(result));
  ccu_cpu_model u_cpu (.clk(clk), .rst_n(rst_n), .req(req), .req_n(req_n), .req_a(req_a),
    .req_b(req_b), .start(start), .n(n), .dataa(dataa), .datab(datab), .done(done),
    .result(result), .busy(busy), .stray(stray), .lat(lat), .res(res));

  function automatic logic [31:0] expv(logic [1:0] s, logic [31:0] a, logic [31:0] b);
    logic [63:0] r;
    r = {a, a} << b[4:0];
    case (s)
      CCU_FN_ADD: return a + b;
      CCU_FN_XOR: return a ^ b;
      CCU_FN_MUL: return a * b;
      default: return r[63:32];
    endcase
  endfunction

  function automatic int explat(logic [1:0] s);
    case (s)
      CCU_FN_ADD: return CCU_ADD_LAT + 1;
      CCU_FN_XOR: return CCU_XOR_LAT + 1;
      CCU_FN_MUL: return CCU_MUL_LAT + 1;
      default: return CCU_ROT_LAT + 1;
    endcase
  endfunction

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic op(input logic [1:0] s, input logic [31:0] a, input logic [31:0] b);
    int k;
    k = 0;
    @(posedge clk);
    req <= 1'b1;
    req_n <= s;
    req_a <= a;
    req_b <= b;
    @(posedge clk);
    req <= 1'b0;
    // let the model's busy settle before polling it
    #1;
    while (busy !== 1'b0 && k < 50) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("busy after op", 32'h0, {31'h0, busy});
    chk("result", expv(s, a, b), res);
    chk("latency", 32'(explat(s)), {24'h0, lat});
    chk("extra done", 32'h0, {31'h0, stray});
  endtask

  task automatic t_funcs;
    op(CCU_FN_ADD, 32'hFFFFFFFF, 32'h00000001);
    op(CCU_FN_XOR, 32'hA5A5A5A5, 32'h0F0F0F0F);
    op(CCU_FN_MUL, 32'h00010003, 32'hFFFF0005);
    op(CCU_FN_ROT, 32'h80000001, 32'h0000001F);
    op(CCU_FN_ROT, 32'h12345678, 32'hFFFFFFE0);
    $display("test funcs done");
  endtask

  // longest then shortest: the registered mux must not leak the old word
  task automatic t_b2b;
    op(CCU_FN_MUL, 32'h0000FFFF, 32'h0000FFFF);
    op(CCU_FN_ADD, 32'h00000002, 32'h00000003);
    op(CCU_FN_ROT, 32'hF0000000, 32'h00000004);
    op(CCU_FN_XOR, 32'hFFFFFFFF, 32'h00000000);
    $display("test back to back done");
  endtask

  task automatic t_reset;
    @(posedge clk);
    req <= 1'b1;
    req_n <= CCU_FN_MUL;
    req_a <= 32'h00000007;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk("result after reset", CCU_RESULT_RST, result);
    chk("done after reset", 32'h0, {31'h0, stray});
    op(CCU_FN_ADD, 32'h00000003, 32'h00000004);
    $display("test reset done");
  endtask

  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_funcs;
    t_b2b;
    t_reset;
    summarize;
  end

  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    summarize;
  end
endmodule // combined_custom_instruction_unit_tb
`default_nettype wire
